// ### core/nfc_tgt_pkg.sv
// shared types and constants of the target activation block
// assumes one clock; rf coding and host link framing live outside
//
// Functional notes
// R1 - init refused with syntax error when general bytes length exceeds 47.
// R2 - init refused with syntax error when historical bytes length exceeds 48.
// R3 - init refused when card-emulation-only and exchange-protocol-only both set.
// R4 - init refused when card-emulation-only set but card emulation disabled.
// R5 - accepted init loads parameters into the interface unit, then starts anticollision.
// R6 - init ends only on a closing initiator frame; reports mode and frame.
// R7 - 106 passive: answer sense, resolve collision with identifier, send select response.
// R8 - 106 attribute request: answer now if automatic, else await general bytes.
// R9 - sleep after selection restarts anticollision; init stays pending.
// R10 - answer-to-select request with emulation enabled gets stored historical bytes answer.
// R11 - proprietary first frame goes to host, or restarts if exchange-only.
// R12 - poll answered with stored response; system code added when byte four is 01.
// R13 - 212/424 attribute request needs identifier match with two zero pad bytes.
// R14 - 212/424 exchange-only refuses every first frame except attribute request.
// R15 - active mode reports settled rate and mode in the mode byte.
// R16 - active mode restarts on non-attribute frame; else automatic or host bytes.
// R17 - host keeps passive-only clear when active activation is wanted.
// R18 - activated device answers select, deselect, release, wakeup and emulation requests.
// R19 - set general bytes refused above 47 bytes or while emulating a card.
// R20 - set general bytes follows init; attribute response then built and sent.
// R21 - get data status carries node-address and more flags; up to 262 bytes.
// R22 - init response carries the first valid frame after initialisation.
// R23 - card-emulation-only refuses any first frame but answer-to-select request.
package nfc_tgt_pkg;
  localparam int          BUF_DEPTH_DEF  = 262;
  localparam logic [7:0]  GB_MAX         = 8'h2f;
  localparam logic [7:0]  HB_MAX         = 8'h30;
  localparam logic [7:0]  POLL_SC_REQ    = 8'h01;
  localparam logic [15:0] ID3_PAD        = 16'h0000;
  localparam int          M_PASSIVE_ONLY = 0;
  localparam int          M_EXCH_ONLY    = 1;
  localparam int          M_CARD_ONLY    = 2;
  localparam int          OM_FRAMING_LSB = 0;
  localparam int          OM_BAUD_LSB    = 4;
  localparam logic [1:0]  FR_TYPE_A      = 2'h0;
  localparam logic [1:0]  FR_PASSIVE_HI  = 2'h1;
  localparam logic [1:0]  FR_ACTIVE      = 2'h2;
  localparam logic [3:0]  REG_CONFIG     = 4'h0;
  localparam logic [3:0]  REG_STATE      = 4'h1;
  localparam logic [3:0]  REG_MODE       = 4'h2;
  localparam int          CFG_CE_BIT     = 0;
  localparam int          CFG_AUTO_BIT   = 1;
  localparam logic [7:0]  CFG_MASK       = 8'h03;
  localparam logic [7:0]  CFG_RST        = 8'h02;
  localparam logic [7:0]  ST_OK          = 8'h00;
  localparam logic [7:0]  ST_BAD_STATE   = 8'h25;
  localparam logic [7:0]  ST_SYNTAX      = 8'h27;
  localparam logic [7:0]  ST_RELEASED    = 8'h29;
  localparam int          STS_MORE_BIT   = 6;
  localparam int          STS_NAD_BIT    = 7;

  typedef enum logic [1:0] {OP_NONE, OP_INIT, OP_SET_GB, OP_GET_DATA} op_t;
  typedef enum logic [3:0] {
    FK_SENSE, FK_ANTICOLL, FK_SELECT_DONE, FK_SLEEP, FK_ATTR, FK_ATS_REQ, FK_PROP,
    FK_POLL, FK_PSL, FK_DSL, FK_RLS, FK_WUP, FK_PPS, FK_SDESEL, FK_INFO
  } frame_kind_t;
  typedef enum logic [3:0] {
    TX_SENSE_RES, TX_UID, TX_SEL_RES, TX_ATTR_RES, TX_ATS, TX_POLL_RES, TX_POLL_RES_SC,
    TX_PSL_RES, TX_DSL_RES, TX_RLS_RES, TX_WUP_RES, TX_PPS_RES, TX_SDESEL_RES
  } tx_kind_t;
  typedef enum logic [1:0] {RATE_106, RATE_212, RATE_424} rate_t;
  typedef enum logic [1:0] {PH_IDLE, PH_COLL, PH_WAIT_GB, PH_ACTIVE} phase_t;
  typedef enum logic [1:0] {PR_NONE, PR_EXCH, PR_CARD} proto_t;
  typedef enum logic [1:0] {LS_ON, LS_DESEL, LS_REL} link_t;

  typedef struct packed {
    logic [15:0] sense_res;
    logic [23:0] target_short_identifier;
    logic [7:0]  sel_res;
    logic [63:0] target_polling_identifier;
    logic [63:0] pad;
    logic [15:0] sys_code;
    logic [79:0] target_exch_id;
  } params_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    logic [7:0] mode;
    logic [7:0] general_bytes_length;
    logic [7:0] historical_bytes_length;
    logic       len_ok;
  } cmd_t;

  typedef struct packed {
    logic       valid;
    op_t        op;
    logic [7:0] status;
    logic [7:0] mode;
    logic [8:0] len;
  } rsp_t;

  typedef struct packed {
    frame_kind_t kind;
    rate_t       rate;
    logic        active;
    logic [7:0]  byte4;
    logic [79:0] initiator_exchange_identifier;
    logic        nad;
    logic        more;
  } rf_frame_t;

  typedef struct packed {
    logic     valid;
    tx_kind_t kind;
  } tx_t;
endpackage

// ### core/nfc_target_activation.sv
`timescale 1ns/1ps
// target activation: host commands, automatic anticollision, first-frame buffer
// assumes rf frames arrive decoded as bytes plus an end strobe with the frame class
module nfc_target_activation
  import nfc_tgt_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
  // clock and reset
  input  logic       clk,
  input  logic       arst_n,
  // register port
  input  logic [3:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_we,
  input  logic       reg_re,
  output logic [7:0] reg_rdata,
  // host commands and answers
  input  cmd_t       cmd,
  input  params_t    cmd_params,
  output logic       cmd_ready,
  output rsp_t       rsp,
  output logic       out_valid,
  output logic [7:0] out_data,
  output logic       out_last,
  input  logic       out_ready,
  // rf side
  input  logic       rx_valid,
  input  logic [7:0] rx_data,
  input  logic       rx_end,
  input  rf_frame_t  rx,
  output tx_t        tx,
  output params_t    unit_params
);

  typedef struct packed {
    phase_t     phase;
    proto_t     proto;
    link_t      link;
    logic       selected;
    logic [7:0] mode_in;
    logic [7:0] mode_out;
    params_t    prm;
    logic [7:0] gb_len;
    logic [7:0] cfg;
    logic [8:0] wptr;
    logic [8:0] len;
    logic       frame_ok;
    logic       nad;
    logic       more;
    op_t        pend;
    rsp_t       rsp;
    tx_t        tx;
    logic       stream;
    logic [8:0] rptr;
    logic [7:0] rdata;
  } st_t;

  st_t        q;
  st_t        d;
  logic [7:0] mem [BUF_DEPTH];
  logic       wr_en;
  logic [8:0] wcnt;
  logic       cmd_go;
  logic       init_err;
  logic       gb_err;
  logic       ce_en;
  logic       auto_rsp;
  logic       exch_only;
  logic       card_only;
  logic       pass_only;
  logic       id_match;
  logic [7:0] gd_sts;

  function automatic logic init_bad(cmd_t c, logic ce);
    logic bad;
    bad = c.general_bytes_length > GB_MAX;                  // [R1]
    bad = bad || c.historical_bytes_length > HB_MAX;        // [R2]
    bad = bad || (c.mode[M_CARD_ONLY] && c.mode[M_EXCH_ONLY]); // [R3]
    bad = bad || (c.mode[M_CARD_ONLY] && !ce);              // [R4]
    return bad || !c.len_ok;
  endfunction

  function automatic logic [7:0] mode_byte(rate_t r, logic [1:0] f);
    logic [7:0] m;
    m = 8'h00;
    m[OM_BAUD_LSB +: 2] = r;
    m[OM_FRAMING_LSB +: 2] = f;
    return m;
  endfunction

  // back to waiting for polling; the pending init is kept
  function automatic st_t restart(st_t s);
    s.selected = 1'b0;
    s.wptr = 9'd0;
    s.phase = PH_COLL;
    return s;
  endfunction

  // closing frame taken: answer the init and hand the frame over
  function automatic st_t accept(st_t s, logic [8:0] n, logic [7:0] m, proto_t p);
    s.len = n;
    s.frame_ok = n != 9'd0;
    s.mode_out = m;
    s.proto = p;
    s.link = LS_ON;
    s.phase = PH_ACTIVE;
    s.wptr = 9'd0;
    s.pend = OP_NONE;
    s.rsp = '{valid: 1'b1, op: OP_INIT, status: ST_OK, mode: m, len: n};
    s.stream = n != 9'd0;
    s.rptr = 9'd0;
    return s;
  endfunction

  assign ce_en     = q.cfg[CFG_CE_BIT];
  assign auto_rsp  = q.cfg[CFG_AUTO_BIT];
  assign exch_only = q.mode_in[M_EXCH_ONLY];
  assign card_only = q.mode_in[M_CARD_ONLY];
  assign pass_only = q.mode_in[M_PASSIVE_ONLY];
  assign init_err  = init_bad(cmd, ce_en);
  assign gb_err    = cmd.general_bytes_length > GB_MAX || q.proto == PR_CARD; // [R19]
  assign id_match  = rx.initiator_exchange_identifier
                     == {q.prm.target_polling_identifier, ID3_PAD}; // [R13]
  assign cmd_ready = !q.stream && !rx_end && q.pend != OP_GET_DATA;
  assign cmd_go    = cmd.valid && cmd_ready;
  assign wr_en     = rx_valid && !q.frame_ok && !q.stream && q.wptr < 9'(BUF_DEPTH)
                     && (q.phase == PH_COLL || q.phase == PH_ACTIVE);
  assign wcnt      = q.wptr + {8'h00, wr_en};

  always_comb begin
    gd_sts = ST_OK;
    gd_sts[STS_NAD_BIT] = q.nad && q.proto == PR_EXCH;   // [R21]
    gd_sts[STS_MORE_BIT] = q.more && q.proto == PR_EXCH; // [R21]
  end

  always_comb begin
    d = q;
    d.rsp.valid = 1'b0;
    d.tx.valid = 1'b0;
    d.rdata = 8'h00;
    if (wr_en) begin
      d.wptr = wcnt;
    end
    if (reg_we && reg_addr == REG_CONFIG) begin
      d.cfg = reg_wdata & CFG_MASK;
    end
    if (reg_re) begin
      case (reg_addr)
        REG_CONFIG: d.rdata = q.cfg;
        REG_STATE:  d.rdata = {2'b00, q.link, q.proto, q.phase};
        REG_MODE:   d.rdata = q.mode_out;
        default:    d.rdata = 8'h00;
      endcase
    end
    // hand stored frame to the host byte by byte
    if (q.stream && out_ready) begin
      d.rptr = q.rptr + 9'd1;
      if (out_last) begin
        d.stream = 1'b0;
        d.frame_ok = 1'b0;
        d.wptr = 9'd0;
      end
    end
    if (rx_end && q.phase == PH_COLL) begin
      d.wptr = 9'd0;
      if (rx.active) begin
        if (pass_only || card_only || rx.kind != FK_ATTR) begin
          d = restart(d); // [R16] [R23]
        end else begin
          d = accept(d, wcnt, mode_byte(rx.rate, FR_ACTIVE), PR_EXCH); // [R15] [R6]
          if (auto_rsp) begin
            d.tx = '{valid: 1'b1, kind: TX_ATTR_RES}; // [R16]
          end else begin
            d.phase = PH_WAIT_GB;
          end
        end
      end else if (rx.rate == RATE_106) begin
        case (rx.kind)
          FK_SENSE: begin
            d.tx = '{valid: 1'b1, kind: TX_SENSE_RES}; // [R7]
          end
          FK_ANTICOLL: begin
            d.tx = '{valid: 1'b1, kind: TX_UID}; // [R7]
          end
          FK_SELECT_DONE: begin
            d.tx = '{valid: 1'b1, kind: TX_SEL_RES}; // [R7]
            d.selected = 1'b1;
          end
          FK_SLEEP: begin
            if (q.selected) begin
              d = restart(d); // [R9]
            end
          end
          FK_ATTR: begin
            if (q.selected && !card_only) begin
              d = accept(d, wcnt, mode_byte(RATE_106, FR_TYPE_A), PR_EXCH); // [R22]
              if (auto_rsp) begin
                d.tx = '{valid: 1'b1, kind: TX_ATTR_RES}; // [R8]
              end else begin
                d.phase = PH_WAIT_GB; // [R8]
              end
            end else begin
              d = restart(d); // [R23]
            end
          end
          FK_ATS_REQ: begin
            if (q.selected && ce_en && !exch_only) begin
              d = accept(d, wcnt, mode_byte(RATE_106, FR_TYPE_A), PR_CARD);
              d.tx = '{valid: 1'b1, kind: TX_ATS}; // [R10]
            end else begin
              d = restart(d);
            end
          end
          FK_PROP: begin
            if (q.selected && !exch_only && !card_only) begin
              d = accept(d, wcnt, mode_byte(RATE_106, FR_TYPE_A), PR_NONE); // [R11]
            end else begin
              d = restart(d); // [R11]
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (rx.kind)
          FK_POLL: begin
            d.tx.valid = 1'b1; // [R12]
            d.tx.kind = rx.byte4 == POLL_SC_REQ ? TX_POLL_RES_SC : TX_POLL_RES; // [R12]
            d.selected = 1'b1;
          end
          FK_ATTR: begin
            if (q.selected && !card_only && id_match) begin
              d = accept(d, wcnt, mode_byte(rx.rate, FR_PASSIVE_HI), PR_EXCH);
              if (auto_rsp) begin
                d.tx = '{valid: 1'b1, kind: TX_ATTR_RES}; // [R13]
              end else begin
                d.phase = PH_WAIT_GB;
              end
            end else begin
              d = restart(d); // [R13]
            end
          end
          FK_PROP: begin
            if (q.selected && !exch_only && !card_only) begin
              d = accept(d, wcnt, mode_byte(rx.rate, FR_PASSIVE_HI), PR_NONE);
            end else begin
              d = restart(d); // [R14]
            end
          end
          default: begin
            if (q.selected) begin
              d = restart(d); // [R14]
            end
          end
        endcase
      end
    end
    if (rx_end && q.phase == PH_ACTIVE) begin
      d.wptr = 9'd0;
      if (q.proto == PR_EXCH) begin
        case (rx.kind)
          FK_PSL: d.tx = '{valid: 1'b1, kind: TX_PSL_RES}; // [R18]
          FK_DSL: begin
            d.tx = '{valid: 1'b1, kind: TX_DSL_RES}; // [R18]
            d.link = LS_DESEL;
          end
          FK_RLS: begin
            d.tx = '{valid: 1'b1, kind: TX_RLS_RES}; // [R18]
            d.link = LS_REL;
          end
          FK_WUP: begin
            if (q.link == LS_DESEL) begin
              d.tx = '{valid: 1'b1, kind: TX_WUP_RES}; // [R18]
              d.link = LS_ON;
            end
          end
          default: begin
          end
        endcase
      end else if (q.proto == PR_CARD) begin
        case (rx.kind)
          FK_PPS: d.tx = '{valid: 1'b1, kind: TX_PPS_RES}; // [R18]
          FK_SDESEL: begin
            d.tx = '{valid: 1'b1, kind: TX_SDESEL_RES}; // [R18]
            d.link = LS_DESEL;
          end
          default: begin
          end
        endcase
      end
      if (rx.kind == FK_INFO && q.proto != PR_NONE && q.link == LS_ON
          && !q.frame_ok && !q.stream) begin
        d.len = wcnt;
        d.frame_ok = 1'b1;
        d.nad = rx.nad;
        d.more = rx.more;
      end
    end
    if (q.pend == OP_GET_DATA && q.link == LS_REL) begin
      d.pend = OP_NONE;
      d.rsp = '{valid: 1'b1, op: OP_GET_DATA, status: ST_RELEASED, mode: q.mode_out,
                len: 9'd0};
    end else if (q.pend == OP_GET_DATA && q.frame_ok && !q.stream) begin
      d.pend = OP_NONE;
      d.rsp = '{valid: 1'b1, op: OP_GET_DATA, status: gd_sts, mode: q.mode_out,
                len: q.len}; // [R21]
      d.stream = q.len != 9'd0;
      d.frame_ok = q.len != 9'd0;
      d.rptr = 9'd0;
    end
    if (cmd_go) begin
      case (cmd.op)
        OP_INIT: begin
          if (init_err) begin
            d.rsp = '{valid: 1'b1, op: OP_INIT, status: ST_SYNTAX, mode: 8'h00,
                      len: 9'd0}; // [R1] [R2] [R3] [R4]
          end else begin
            d.prm = cmd_params; // [R5]
            d.mode_in = cmd.mode;
            d.gb_len = cmd.general_bytes_length;
            d.mode_out = 8'h00;
            d.proto = PR_NONE;
            d.link = LS_ON;
            d.frame_ok = 1'b0;
            d.pend = OP_INIT;
            d = restart(d); // [R5]
          end
        end
        OP_SET_GB: begin
          d.rsp = '{valid: 1'b1, op: OP_SET_GB, status: gb_err ? ST_SYNTAX : ST_OK,
                    mode: q.mode_out, len: 9'd0}; // [R19]
          if (!gb_err) begin
            d.gb_len = cmd.general_bytes_length;
            if (q.phase == PH_WAIT_GB) begin
              d.tx = '{valid: 1'b1, kind: TX_ATTR_RES}; // [R20]
              d.phase = PH_ACTIVE;
            end
          end
        end
        OP_GET_DATA: begin
          if (q.link == LS_REL) begin
            d.rsp = '{valid: 1'b1, op: OP_GET_DATA, status: ST_RELEASED,
                      mode: q.mode_out, len: 9'd0};
          end else if (q.phase != PH_ACTIVE || q.proto == PR_NONE) begin
            d.rsp = '{valid: 1'b1, op: OP_GET_DATA, status: ST_BAD_STATE,
                      mode: q.mode_out, len: 9'd0};
          end else begin
            d.pend = OP_GET_DATA;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.cfg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  // frame buffer holds data only, so it needs no reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[q.wptr] <= rx_data;
    end
  end

  assign reg_rdata  = q.rdata;
  assign rsp        = q.rsp;
  assign tx         = q.tx;
  assign unit_params = q.prm;
  assign out_valid  = q.stream;
  assign out_data   = mem[q.rptr];
  assign out_last   = q.stream && q.rptr == q.len - 9'd1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  gb_len_a: assert property ( // [R1]
    cmd_go && cmd.op == OP_INIT && cmd.general_bytes_length > GB_MAX
    |=> rsp.valid && rsp.status == ST_SYNTAX && q.pend == $past(q.pend))
    else $error("long general bytes not refused");
  hb_len_a: assert property ( // [R2]
    cmd_go && cmd.op == OP_INIT && cmd.historical_bytes_length > HB_MAX
    |=> rsp.valid && rsp.status == ST_SYNTAX)
    else $error("long historical bytes not refused");
  both_only_a: assert property ( // [R3]
    cmd_go && cmd.op == OP_INIT && cmd.mode[M_CARD_ONLY] && cmd.mode[M_EXCH_ONLY]
    |=> rsp.status == ST_SYNTAX)
    else $error("conflicting only flags accepted");
  ce_off_a: assert property ( // [R4]
    cmd_go && cmd.op == OP_INIT && cmd.mode[M_CARD_ONLY] && !ce_en
    |=> rsp.valid && rsp.status == ST_SYNTAX)
    else $error("emulation-only accepted while disabled");
  init_load_a: assert property ( // [R5]
    cmd_go && cmd.op == OP_INIT && !init_err
    |=> unit_params == $past(cmd_params) && q.phase == PH_COLL && !rsp.valid)
    else $error("init parameters not loaded");
  sense_ans_a: assert property ( // [R7]
    rx_end && q.phase == PH_COLL && !rx.active && rx.rate == RATE_106
    && rx.kind == FK_SENSE |=> tx.valid && tx.kind == TX_SENSE_RES)
    else $error("sense request not answered");
  sleep_a: assert property ( // [R9]
    rx_end && q.phase == PH_COLL && !rx.active && rx.rate == RATE_106
    && rx.kind == FK_SLEEP && q.selected
    |=> !q.selected && q.phase == PH_COLL && q.pend == $past(q.pend) && !rsp.valid)
    else $error("sleep did not restart anticollision");
  poll_sc_a: assert property ( // [R12]
    rx_end && q.phase == PH_COLL && !rx.active && rx.rate != RATE_106
    && rx.kind == FK_POLL
    |=> tx.valid && (tx.kind == TX_POLL_RES_SC) == ($past(rx.byte4) == POLL_SC_REQ))
    else $error("poll answer system code wrong");
  id_miss_a: assert property ( // [R13]
    rx_end && q.phase == PH_COLL && !rx.active && rx.rate != RATE_106
    && rx.kind == FK_ATTR && !id_match
    |=> !rsp.valid && !tx.valid && q.phase == PH_COLL && !q.selected)
    else $error("identifier mismatch accepted");
  gb_card_a: assert property ( // [R19]
    cmd_go && cmd.op == OP_SET_GB && q.proto == PR_CARD
    |=> rsp.valid && rsp.status == ST_SYNTAX && !tx.valid)
    else $error("general bytes taken while emulating card");
  wait_gb_a: assert property ( // [R20]
    cmd_go && cmd.op == OP_SET_GB && q.phase == PH_WAIT_GB && !gb_err
    |=> tx.valid && tx.kind == TX_ATTR_RES && q.phase == PH_ACTIVE)
    else $error("attribute response not sent after general bytes");
  init_frame_a: assert property ( // [R22]
    rsp.valid && rsp.op == OP_INIT && rsp.status == ST_OK && rsp.len != 9'd0
    |-> out_valid && q.rptr == 9'd0)
    else $error("first frame not handed to host");

  init_done_c: cover property (rsp.valid && rsp.op == OP_INIT && rsp.status == ST_OK);
  attr_tx_c: cover property (tx.valid && tx.kind == TX_ATTR_RES);
  data_end_c: cover property (out_valid && out_ready && out_last && q.pend == OP_NONE);

endmodule

// ### verif/rf_initiator_model.sv
`timescale 1ns/1ps
// rf initiator stand-in: sends decoded frames to the target block
// assumes the bench calls send from its main sequence on clk
module rf_initiator_model
  import nfc_tgt_pkg::*;
(
  // clock
  input  wire logic  clk,
  // decoded frames toward the block
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_end,
  output rf_frame_t  rx
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_end   = 1'b0;
    rx       = '0;
  end
  // gap idle cycles, payload bytes, then one end strobe with the frame class
  task automatic send(input int gap, input frame_kind_t k, input rate_t r, input logic act,
                      input logic [7:0] b4, input logic [79:0] id, input logic [7:0] pl[$]);
    repeat (gap) @(posedge clk);
    foreach (pl[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= pl[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
    rx_end   <= 1'b1;
    rx       <= '{kind: k, rate: r, active: act, byte4: b4,
                  initiator_exchange_identifier: id, nad: 1'b0, more: 1'b0};
    @(posedge clk);
    rx_end   <= 1'b0;
    rx       <= rf_frame_t'(~rx);
  endtask
endmodule

// ### verif/nfc_target_activation_test.sv
`timescale 1ns/1ps
// self-checking bench of the target activation block
// assumes rf_initiator_model drives the rf side; host always takes out bytes
module nfc_target_activation_test;
  import nfc_tgt_pkg::*;
  logic        clk, arst_n, reg_we, reg_re, cmd_ready, out_valid, out_last, out_ready;
  logic        rx_valid, rx_end;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, out_data, rx_data;
  cmd_t        cmd;
  params_t     cmd_params, unit_params;
  rsp_t        rsp;
  rf_frame_t   rx;
  tx_t         tx;
  int          bad_count, comparisons;
  logic [31:0] seed = 32'd37;
  logic [7:0]  exp_q[$];
  logic [79:0] good_id;

  nfc_target_activation i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .cmd(cmd), .cmd_params(cmd_params), .cmd_ready(cmd_ready), .rsp(rsp),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx(rx), .tx(tx),
    .unit_params(unit_params));
  rf_initiator_model i_rf (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx(rx));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic tally_and_finish();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input string n, input logic [271:0] e, input logic [271:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic hang(input string n);
    bad_count++;
    $display("MISMATCH %s expected done seen timeout", n);
    tally_and_finish();
  endtask
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we   <= wr;
    reg_re   <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    #1 if (!wr) chk_val("reg_rdata", d, reg_rdata);
  endtask
  task automatic do_cmd(input op_t o, input logic [7:0] m, gl, hl);
    int i;
    @(posedge clk);
    cmd <= '{valid: 1'b1, op: o, mode: m, general_bytes_length: gl,
             historical_bytes_length: hl, len_ok: 1'b1};
    @(negedge clk);
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
    if (i == 50) hang("cmd_ready");
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask
  // one frame from the initiator; tx is the automatic answer one cycle after its end
  task automatic frame(input frame_kind_t k, input rate_t r, input logic act,
                       input logic [7:0] b4, input logic [79:0] id, input int n,
                       input logic ev, input tx_kind_t ek);
    exp_q = {};
    repeat (n) exp_q.push_back(rnd());
    i_rf.send(n % 3, k, r, act, b4, id, exp_q);
    #1 chk_val("tx", ev ? {ev, ek} : 5'h0, tx.valid ? {tx.valid, tx.kind} : 5'h0);
  endtask
  task automatic chk_init(input logic [7:0] md);
    logic [7:0] got[$];
    int i;
    chk_val("rsp", {1'b1, OP_INIT, ST_OK, md, 9'(exp_q.size())},
            {rsp.valid, rsp.op, rsp.status, rsp.mode, rsp.len});
    for (i = 0; i < 300 && !(got.size() > 0 && out_last); i++) begin
      @(negedge clk);
      if (out_valid === 1'b1) got.push_back(out_data);
    end
    if (i == 300) hang("out_last");
    chk_val("first_frame", exp_q.size(), got.size());
    foreach (exp_q[j]) chk_val("first_frame_byte", exp_q[j], got[j]);
  endtask

  initial begin
    {arst_n, reg_we, reg_re, reg_addr, reg_wdata, cmd} = '0;
    out_ready = 1'b1;
    for (int i = 0; i < 34; i++) cmd_params[i*8 +: 8] = rnd();
    good_id = {cmd_params.target_polling_identifier, ID3_PAD};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    reg_op(1'b0, REG_CONFIG, CFG_RST);
    reg_op(1'b0, 4'hf, 8'h00);
    do_cmd(OP_INIT, 8'h00, 8'h30, 8'h00);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    do_cmd(OP_INIT, 8'h00, 8'h00, 8'h31);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    do_cmd(OP_INIT, 8'h06, 8'h00, 8'h00);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    do_cmd(OP_INIT, 8'h04, 8'h00, 8'h00);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    reg_op(1'b1, REG_CONFIG, 8'hff);
    reg_op(1'b0, REG_CONFIG, 8'h03);
    $display("test errors done");
    do_cmd(OP_INIT, 8'h00, GB_MAX, HB_MAX);
    chk_val("rsp_valid", 1'b0, rsp.valid);
    chk_val("unit_params", cmd_params, unit_params);
    for (int rd = 0; rd < 2; rd++) begin
      frame(FK_SENSE, RATE_106, 1'b0, 8'h00, '0, 0, 1'b1, TX_SENSE_RES);
      frame(FK_ANTICOLL, RATE_106, 1'b0, 8'h00, '0, 2, 1'b1, TX_UID);
      frame(FK_SELECT_DONE, RATE_106, 1'b0, 8'h00, '0, 1, 1'b1, TX_SEL_RES);
      if (rd == 0) frame(FK_SLEEP, RATE_106, 1'b0, 8'h00, '0, 2, 1'b0, TX_UID);
      if (rd == 0) chk_val("rsp_valid", 1'b0, rsp.valid);
    end
    frame(FK_ATTR, RATE_106, 1'b0, 8'h00, '0, 5, 1'b1, TX_ATTR_RES);
    chk_init(8'h00);
    do_cmd(OP_SET_GB, 8'h00, 8'h30, 8'h00);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    $display("test 106 passive done");
    reg_op(1'b1, REG_CONFIG, 8'h01);
    do_cmd(OP_INIT, 8'h00, 8'h00, 8'h00);
    frame(FK_POLL, RATE_212, 1'b0, POLL_SC_REQ, '0, 3, 1'b1, TX_POLL_RES_SC);
    frame(FK_POLL, RATE_212, 1'b0, 8'h00, '0, 3, 1'b1, TX_POLL_RES);
    frame(FK_ATTR, RATE_212, 1'b0, 8'h00, ~good_id, 4, 1'b0, TX_UID);
    chk_val("rsp_valid", 1'b0, rsp.valid);
    frame(FK_POLL, RATE_212, 1'b0, 8'h00, '0, 1, 1'b1, TX_POLL_RES);
    frame(FK_ATTR, RATE_212, 1'b0, 8'h00, good_id, 3, 1'b0, TX_UID);
    chk_init(8'h11);
    do_cmd(OP_SET_GB, 8'h00, 8'h0a, 8'h00);
    chk_val("rsp", {1'b1, ST_OK}, {rsp.valid, rsp.status});
    chk_val("tx", {1'b1, TX_ATTR_RES}, {tx.valid, tx.kind});
    $display("test 212 passive done");
    do_cmd(OP_INIT, 8'h00, 8'h00, 8'h00);
    frame(FK_INFO, RATE_424, 1'b1, 8'h00, '0, 2, 1'b0, TX_UID);
    chk_val("rsp_valid", 1'b0, rsp.valid);
    frame(FK_ATTR, RATE_424, 1'b1, 8'h00, good_id, 4, 1'b0, TX_UID);
    chk_init(8'h22);
    $display("test active done");
    do_cmd(OP_INIT, 8'h04, 8'h00, 8'h00);
    frame(FK_SELECT_DONE, RATE_106, 1'b0, 8'h00, '0, 1, 1'b1, TX_SEL_RES);
    frame(FK_ATTR, RATE_106, 1'b0, 8'h00, '0, 2, 1'b0, TX_UID);
    frame(FK_SELECT_DONE, RATE_106, 1'b0, 8'h00, '0, 1, 1'b1, TX_SEL_RES);
    frame(FK_ATS_REQ, RATE_106, 1'b0, 8'h00, '0, 2, 1'b1, TX_ATS);
    chk_init(8'h00);
    do_cmd(OP_SET_GB, 8'h00, 8'h00, 8'h00);
    chk_val("rsp", {1'b1, ST_SYNTAX}, {rsp.valid, rsp.status});
    frame(FK_PPS, RATE_106, 1'b0, 8'h00, '0, 0, 1'b1, TX_PPS_RES);
    $display("test card emulation done");
    tally_and_finish();
  end
endmodule
